// ### sent_slot_defines.vh
// constants for the shared sent slot option logic
`ifndef SENT_SLOT_DEFINES_VH
`define SENT_SLOT_DEFINES_VH

// register bus shape
`define ADDR_W 14
`define DATA_W 32
`define IDX_W 12

// register indices, byte address is four times the index
`define IDX_PULSE_CFG 12'h308
`define IDX_MARK_CFG 12'h317
`define IDX_SLOT_CFG 12'h319
`define IDX_VARIANT_CFG 12'h320
`define IDX_SLOT_STATUS 12'h321

// field positions in the pulse config register
`define POS_PULSE_ADJ_LO 18
`define POS_PULSE_ADJ_HI 19
`define POS_MAX_ID_LO 16
`define POS_MAX_ID_HI 17
// field positions in the mark config register
`define POS_SLOT_MARK 3
// field positions in the slot config register
`define POS_IDLE_RESYNC 23
`define POS_STAY_OFFLINE 19
`define POS_ZERO_SAMPLE 10
// field positions in the variant config register
`define POS_VARIANT_LO 0
`define POS_VARIANT_HI 2
`define POS_SENSOR_ID_LO 4
`define POS_SENSOR_ID_HI 5
// field positions in the status register
`define POS_ONLINE 0
`define POS_SLOT_LO 1
`define POS_SLOT_HI 2

// reset values of the configuration fields
`define RST_PULSE_ADJ 2'h0
`define RST_MAX_ID 2'h0
`define RST_SLOT_MARK 1'h0
`define RST_IDLE_RESYNC 1'h0
`define RST_STAY_OFFLINE 1'h0
`define RST_ZERO_SAMPLE 1'h0
`define RST_VARIANT 3'h0
`define RST_SENSOR_ID 2'h0

// sent variants that run the shared bus slot scheme
`define VARIANT_SHORT_SHARED 3'h6
`define VARIANT_LONG_SHARED 3'h7

// timing: tick period and clock period in ns
`define TICK_TIME_NS 3000
`define CLOCK_PERIOD_NS 8
`define TICK_CYCLES ((`TICK_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

// pulse classification in ticks
`define TICK_CNT_W 9
`define IDLE_LIMIT_TICKS 9'h1fe
`define OUT_MIN_TICKS 9'h009
`define OUT_MAX_TICKS 9'h015
`define SYNC_MIN_TICKS 9'h028
`define SYNC_MAX_TICKS 9'h040
`define MARK_UNIT_TICKS 9'h004

`endif

// ### sent_pulse_meter.v
// measures low pulses and idle time on the shared sent line in ticks
`timescale 1ns/1ps
`include "sent_slot_defines.vh"

module sent_pulse_meter #(
    parameter CNT_W = `TICK_CNT_W,
    parameter [CNT_W-1:0] IDLE_LIMIT = `IDLE_LIMIT_TICKS
) (
    input wire clock,
    input wire rst,
    input wire tick,
    input wire lineIn,
    output wire pulseDone,
    output wire [CNT_W-1:0] pulseWidth,
    output wire idleTimeout
);

    reg lineDly_reg;
    reg [CNT_W-1:0] lowCnt_reg;
    reg [CNT_W-1:0] highCnt_reg;
    reg pulseDone_reg;
    reg [CNT_W-1:0] pulseWidth_reg;
    reg idleTimeout_reg;

    wire riseEdge = lineIn & ~lineDly_reg;
    wire fallEdge = ~lineIn & lineDly_reg;
    wire [CNT_W-1:0] cntMax = {CNT_W{1'b1}};

    assign pulseDone = pulseDone_reg;
    assign pulseWidth = pulseWidth_reg;
    assign idleTimeout = idleTimeout_reg;

    // counters saturate so a stuck line never wraps into a valid width
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            lineDly_reg <= 1'b1;
            lowCnt_reg <= {CNT_W{1'b0}};
            highCnt_reg <= {CNT_W{1'b0}};
            pulseDone_reg <= 1'b0;
            pulseWidth_reg <= {CNT_W{1'b0}};
            idleTimeout_reg <= 1'b0;
        end else begin
            lineDly_reg <= lineIn;
            pulseDone_reg <= riseEdge;
            idleTimeout_reg <= 1'b0;
            if (riseEdge) begin
                pulseWidth_reg <= lowCnt_reg;
            end
            if (fallEdge) begin
                lowCnt_reg <= {CNT_W{1'b0}};
            end else if (~lineIn && tick && lowCnt_reg != cntMax) begin
                lowCnt_reg <= lowCnt_reg + 1'b1;
            end
            // one event once the line has been idle beyond the limit
            if (~lineIn) begin
                highCnt_reg <= {CNT_W{1'b0}};
            end else if (tick && highCnt_reg != cntMax) begin
                highCnt_reg <= highCnt_reg + 1'b1;
                idleTimeout_reg <= (highCnt_reg == IDLE_LIMIT);
            end
        end
    end

endmodule

// ### shared_sent_slot_options.v
// shared sent slot options: offline start, slot marking, zero_slot_sampling
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "sent_slot_defines.vh"

//////////////////////////////////////////////////////////////////////////////
module shared_sent_slot_options #(
    parameter TICK_CYCLES = `TICK_CYCLES,
    parameter CNT_W = `TICK_CNT_W,
    parameter [CNT_W-1:0] MARK_UNIT = `MARK_UNIT_TICKS,
    parameter [0:0] STAY_OFFLINE_DEFAULT = `RST_STAY_OFFLINE
) (
    input wire clock,
    input wire rst,
    input wire [`ADDR_W-1:0] addr,
    input wire [`DATA_W-1:0] writeData,
    input wire writeStrobe,
    input wire readStrobe,
    output wire [`DATA_W-1:0] readData,
    input wire lineIn,
    output wire lineOut,
    output wire lineOe,
    output wire frameRequest,
    output wire sampleHold,
    output wire online
);

    //////////////////////////////////////////////////////////////////////////
    // register decode

    // true when the byte address hits the word of a register index
    function isReg;
        input [`ADDR_W-1:0] a;
        input [`IDX_W-1:0] idx;
        begin
            isReg = (a == {idx, 2'b00});
        end
    endfunction

    reg [1:0] pulseAdj_reg;
    reg [1:0] maxId_reg;
    reg slotMark_reg;
    reg idleResync_reg;
    reg stayOffline_reg;
    reg zeroSample_reg;
    reg [2:0] variant_reg;
    reg [1:0] sensorId_reg;
    reg [`DATA_W-1:0] readData_reg;

    reg online_reg;
    reg porPending_reg;
    reg [1:0] slot_reg;
    reg [1:0] slot_next;
    reg frameRequest_reg;
    reg sampleHold_reg;
    reg lineOut_reg;
    reg lineOe_reg;

    assign readData = readData_reg;

    // configuration writes, one word per register
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            pulseAdj_reg <= `RST_PULSE_ADJ;
            maxId_reg <= `RST_MAX_ID;
            slotMark_reg <= `RST_SLOT_MARK;
            idleResync_reg <= `RST_IDLE_RESYNC;
            stayOffline_reg <= STAY_OFFLINE_DEFAULT;
            zeroSample_reg <= `RST_ZERO_SAMPLE;
            variant_reg <= `RST_VARIANT;
            sensorId_reg <= `RST_SENSOR_ID;
        end else if (writeStrobe) begin
            if (isReg(addr, `IDX_PULSE_CFG)) begin
                pulseAdj_reg <=
                    writeData[`POS_PULSE_ADJ_HI:`POS_PULSE_ADJ_LO];
                maxId_reg <= writeData[`POS_MAX_ID_HI:`POS_MAX_ID_LO];
            end
            if (isReg(addr, `IDX_MARK_CFG)) begin
                slotMark_reg <= writeData[`POS_SLOT_MARK];
            end
            if (isReg(addr, `IDX_SLOT_CFG)) begin
                idleResync_reg <= writeData[`POS_IDLE_RESYNC];
                stayOffline_reg <= writeData[`POS_STAY_OFFLINE];
                zeroSample_reg <= writeData[`POS_ZERO_SAMPLE];
            end
            if (isReg(addr, `IDX_VARIANT_CFG)) begin
                variant_reg <= writeData[`POS_VARIANT_HI:`POS_VARIANT_LO];
                sensorId_reg <=
                    writeData[`POS_SENSOR_ID_HI:`POS_SENSOR_ID_LO];
            end
        end
    end

    // read data stand only in the cycle after the strobe, else zero
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            readData_reg <= {`DATA_W{1'b0}};
        end else begin
            readData_reg <= {`DATA_W{1'b0}};
            if (readStrobe) begin
                if (isReg(addr, `IDX_PULSE_CFG)) begin
                    readData_reg[`POS_PULSE_ADJ_HI:`POS_PULSE_ADJ_LO] <=
                        pulseAdj_reg;
                    readData_reg[`POS_MAX_ID_HI:`POS_MAX_ID_LO] <=
                        maxId_reg;
                end
                if (isReg(addr, `IDX_MARK_CFG)) begin
                    readData_reg[`POS_SLOT_MARK] <= slotMark_reg;
                end
                if (isReg(addr, `IDX_SLOT_CFG)) begin
                    readData_reg[`POS_IDLE_RESYNC] <= idleResync_reg;
                    readData_reg[`POS_STAY_OFFLINE] <= stayOffline_reg;
                    readData_reg[`POS_ZERO_SAMPLE] <= zeroSample_reg;
                end
                if (isReg(addr, `IDX_VARIANT_CFG)) begin
                    readData_reg[`POS_VARIANT_HI:`POS_VARIANT_LO] <=
                        variant_reg;
                    readData_reg[`POS_SENSOR_ID_HI:`POS_SENSOR_ID_LO] <=
                        sensorId_reg;
                end
                if (isReg(addr, `IDX_SLOT_STATUS)) begin
                    readData_reg[`POS_ONLINE] <= online_reg;
                    readData_reg[`POS_SLOT_HI:`POS_SLOT_LO] <= slot_reg;
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // tick generation and line measurement

    reg [15:0] tickCnt_reg;
    reg tick_reg;

    // free running tick divider from the system clock
    // it never pauses, so every width and mark count shares one time base
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            tickCnt_reg <= 16'h0000;
            tick_reg <= 1'b0;
        end else if (tickCnt_reg == TICK_CYCLES[15:0] - 16'h0001) begin
            tickCnt_reg <= 16'h0000;
            tick_reg <= 1'b1;
        end else begin
            tickCnt_reg <= tickCnt_reg + 16'h0001;
            tick_reg <= 1'b0;
        end
    end

    wire pulseDone;
    wire [CNT_W-1:0] pulseWidth;
    wire idleTimeout;

    // the meter sees the raw pin; inputs are synchronous to this clock
    sent_pulse_meter #(
        .CNT_W(CNT_W),
        .IDLE_LIMIT(`IDLE_LIMIT_TICKS)
    ) meter (
        .clock(clock),
        .rst(rst),
        .tick(tick_reg),
        .lineIn(lineIn),
        .pulseDone(pulseDone),
        .pulseWidth(pulseWidth),
        .idleTimeout(idleTimeout)
    );

    //////////////////////////////////////////////////////////////////////////
    // pulse classification

    wire sharedMode = (variant_reg == `VARIANT_SHORT_SHARED) ||
        (variant_reg == `VARIANT_LONG_SHARED);
    wire longShared = (variant_reg == `VARIANT_LONG_SHARED);

    // widening only in long shared mode; it guards short tick times
    wire [CNT_W-1:0] outMin = `OUT_MIN_TICKS +
        (longShared ? {{(CNT_W-2){1'b0}}, pulseAdj_reg} : {CNT_W{1'b0}});
    wire outPulse = pulseDone && (pulseWidth >= outMin) &&
        (pulseWidth <= `OUT_MAX_TICKS);
    wire syncPulse = pulseDone && (pulseWidth >= `SYNC_MIN_TICKS) &&
        (pulseWidth <= `SYNC_MAX_TICKS);
    wire idleSync = idleTimeout && idleResync_reg && sharedMode;
    wire syncEvent = sharedMode && (syncPulse || idleSync);

    //////////////////////////////////////////////////////////////////////////
    // slot counter

    // next slot: sync forces zero, an output request steps up and wraps to zero after max id
    always @* begin
        slot_next = slot_reg;
        if (syncEvent) begin
            slot_next = 2'h0;
        end else if (outPulse && sharedMode) begin
            slot_next = (slot_reg == maxId_reg) ? 2'h0 : slot_reg + 2'h1;
        end
    end

    // slot zero is reached by a wrap through an output request or a sync
    wire slotToZero = sharedMode && (syncEvent ||
        (outPulse && slot_reg != 2'h0 && slot_next == 2'h0));
    // outside the shared variants every valid output request is ours
    wire addressed = outPulse && (!sharedMode || slot_next == sensorId_reg);

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            slot_reg <= 2'h0;
        end else begin
            slot_reg <= slot_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // online state

    // the power-on decision is taken outside the asynchronous reset, at
    // the first clock in a shared variant after reset release; the
    // variant resets to a plain one, so deciding at release would never
    // see the stay-offline option; plain variants are always online
    // limitation: later writes never repeat the decision, only a reset does
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            online_reg <= 1'b0;
            porPending_reg <= 1'b1;
        end else begin
            if (porPending_reg && sharedMode) begin
                porPending_reg <= 1'b0;
                online_reg <= !stayOffline_reg || syncEvent;
            end else if (!sharedMode) begin
                online_reg <= 1'b1;
            end else if (syncEvent) begin
                online_reg <= 1'b1;
            end
        end
    end

    assign online = online_reg;

    //////////////////////////////////////////////////////////////////////////
    // frame request, sampling and slot marking

    // one mark unit per id step, so id 0 has the shortest mark
    reg [CNT_W-1:0] markCnt_reg;
    wire [CNT_W-1:0] markLen =
        MARK_UNIT * ({{(CNT_W-2){1'b0}}, sensorId_reg} + 1'b1);
    // frames go out while online or, once decided, in a plain variant; a plain variant is online from the
    // first clock after reset, and a shared one can send in its decision cycle on the online state of the plain phase
    wire canSend = online_reg || porPending_reg == 1'b0 && !sharedMode;

    // frames are encoded elsewhere; this only says when our slot is due
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            frameRequest_reg <= 1'b0;
            sampleHold_reg <= 1'b0;
        end else begin
            frameRequest_reg <= addressed && canSend;
            sampleHold_reg <= slotToZero && zeroSample_reg;
        end
    end

    // bus-high delay after our addressing pulse, length grows with id
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            markCnt_reg <= {CNT_W{1'b0}};
            lineOut_reg <= 1'b0;
            lineOe_reg <= 1'b0;
        end else begin
            if (addressed && sharedMode && slotMark_reg && online_reg) begin
                markCnt_reg <= markLen;
                lineOut_reg <= 1'b1;
                lineOe_reg <= 1'b1;
            end else if (markCnt_reg != {CNT_W{1'b0}}) begin
                if (tick_reg) begin
                    markCnt_reg <= markCnt_reg - 1'b1;
                end
                // leaving shared mode or going offline cuts the mark short
                if (!sharedMode || !online_reg) begin
                    markCnt_reg <= {CNT_W{1'b0}};
                end
            end else begin
                lineOut_reg <= 1'b0;
                lineOe_reg <= 1'b0;
            end
        end
    end

    assign frameRequest = frameRequest_reg;
    assign sampleHold = sampleHold_reg;
    assign lineOut = lineOut_reg;
    assign lineOe = lineOe_reg;

endmodule

// ### slot_options_checker_sva.sv
// port assertions for the shared sent slot option block
`timescale 1ns/1ps
`include "sent_slot_defines.vh"
module slot_options_checker #(
    parameter TICK_CYCLES = 4
) (
    input wire clock,
    input wire rst,
    input wire readStrobe,
    input wire [`DATA_W-1:0] readData,
    input wire lineIn,
    input wire lineOut,
    input wire lineOe,
    input wire frameRequest,
    input wire sampleHold,
    input wire online
);
    localparam int MARK_MAX = 17 * 4 * TICK_CYCLES;
    reg [7:0] sinceLow_reg;
    reg [15:0] oeLen_reg;
    // cycles since the line was low, and length of the current mark
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            sinceLow_reg <= 8'hff;
            oeLen_reg <= 16'h0000;
        end else begin
            if (!lineIn)
                sinceLow_reg <= 8'h00;
            else if (sinceLow_reg != 8'hff)
                sinceLow_reg <= sinceLow_reg + 8'h01;
            oeLen_reg <= lineOe ? oeLen_reg + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    chk_read_quiet: assert property (
        !readStrobe |=> readData == 0) else $error("stray read data");
    chk_frame_single: assert property (
        frameRequest |=> !frameRequest) else $error("frame pulse too long");
    chk_sample_single: assert property (
        sampleHold |=> !sampleHold) else $error("sample pulse too long");
    chk_offline_quiet: assert property (
        !online |-> !frameRequest && !lineOe) else $error("sent offline");
    chk_mark_level: assert property (
        lineOe |-> lineOut) else $error("mark drives low");
    chk_frame_cause: assert property (
        frameRequest |-> sinceLow_reg <= 8'h06) else $error("frame no pulse");
    chk_mark_cause: assert property (
        $rose(lineOe) |-> sinceLow_reg <= 8'h06) else $error("mark no pulse");
    chk_mark_bound: assert property (
        oeLen_reg <= MARK_MAX) else $error("mark too long");
    cover property (frameRequest);
    cover property (sampleHold);
    cover property ($rose(lineOe));
    cover property (!online ##1 online);
endmodule

bind shared_sent_slot_options slot_options_checker #(
    .TICK_CYCLES(TICK_CYCLES)
) chk (.clock(clock), .rst(rst), .readStrobe(readStrobe),
    .readData(readData), .lineIn(lineIn), .lineOut(lineOut),
    .lineOe(lineOe), .frameRequest(frameRequest),
    .sampleHold(sampleHold), .online(online));

// ### sent_controller_model.sv
// receiving controller that pulls the shared sent line low
`timescale 1ns/1ps
module sent_controller_model #(
    parameter TICK_CYCLES = 4
) (
    input wire clock,
    input wire deviceOe,
    input wire deviceOut,
    output wire lineLevel
);
    reg pullLow_reg = 1'b0;
    // pulled-up line: low while we pull, else the mark or idle high
    assign lineLevel = pullLow_reg ? 1'b0 : (deviceOe ? deviceOut : 1'b1);
    // one function pulse, width chosen by caller, then a high gap
    task send_pulse(input int ticks, input int gapTicks);
        @(posedge clock);
        pullLow_reg <= 1'b1;
        repeat (ticks * TICK_CYCLES) @(posedge clock);
        pullLow_reg <= 1'b0;
        repeat (gapTicks * TICK_CYCLES) @(posedge clock);
    endtask
endmodule

// ### tb.sv
// self-checking bench for the shared sent slot options
`timescale 1ns/1ps
`include "sent_slot_defines.vh"
module tb;
    localparam TC = 4;
    localparam [13:0] A_PULSE = {`IDX_PULSE_CFG, 2'b00};
    localparam [13:0] A_MARK = {`IDX_MARK_CFG, 2'b00};
    localparam [13:0] A_SLOT = {`IDX_SLOT_CFG, 2'b00};
    localparam [13:0] A_VAR = {`IDX_VARIANT_CFG, 2'b00};
    localparam [13:0] A_STAT = {`IDX_SLOT_STATUS, 2'b00};
    reg clock = 1'b0;
    reg rst = 1'b1;
    reg [`ADDR_W-1:0] addr = 14'h0000;
    reg [`DATA_W-1:0] writeData = 32'h00000000;
    reg writeStrobe = 1'b0;
    reg readStrobe = 1'b0;
    wire [`DATA_W-1:0] readData;
    wire lineIn, lineOut, lineOe, frameRequest, sampleHold, online;
    integer err_count = 0;
    integer checks = 0;
    integer frames = 0, samples = 0, marks = 0;
    reg oePrev = 1'b0;
    reg [`DATA_W-1:0] rdv;

    always #4 clock = ~clock;

    shared_sent_slot_options #(.TICK_CYCLES(TC)) uut (.clock(clock),
        .rst(rst), .addr(addr), .writeData(writeData),
        .writeStrobe(writeStrobe), .readStrobe(readStrobe),
        .readData(readData), .lineIn(lineIn), .lineOut(lineOut),
        .lineOe(lineOe), .frameRequest(frameRequest),
        .sampleHold(sampleHold), .online(online));
    sent_controller_model #(.TICK_CYCLES(TC)) ctrl (.clock(clock),
        .deviceOe(lineOe), .deviceOut(lineOut), .lineLevel(lineIn));

    // running event counts; scenarios compare deltas, never clear them
    always @(posedge clock) begin
        frames <= frames + (frameRequest === 1'b1);
        samples <= samples + (sampleHold === 1'b1);
        marks <= marks + (lineOe === 1'b1 && oePrev !== 1'b1);
        oePrev <= lineOe;
    end

    task report_and_stop;
        if (err_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task chk(input bit ok, input string msg);
        checks = checks + 1;
        if (!ok) begin
            err_count = err_count + 1;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask
    task wr(input [13:0] a, input [31:0] d);
        @(posedge clock);
        writeStrobe <= 1'b1;
        addr <= a;
        writeData <= d;
        @(posedge clock);
        writeStrobe <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task rd(input [13:0] a);
        @(posedge clock);
        readStrobe <= 1'b1;
        addr <= a;
        @(posedge clock);
        readStrobe <= 1'b0;
        #1 rdv = readData;
    endtask
    task cfg(input [2:0] v, input [1:0] id, input [1:0] mx,
        input [1:0] adj, input mk, input is, input zs);
        wr(A_VAR, {26'h0000000, id, 1'b0, v});
        wr(A_PULSE, {12'h000, adj, mx, 16'h0000});
        wr(A_MARK, {28'h0000000, mk, 3'h0});
        wr(A_SLOT, {8'h00, is, 12'h000, zs, 10'h000});
    endtask

    task t_reset;
        chk(online === 1'b1, "not online after reset");
        rd(A_STAT);
        chk(rdv === 32'h00000001, "status after reset");
        rd(A_SLOT);
        chk(rdv === 32'h00000000, "slot config reset");
        rd(14'h3ffc);
        chk(rdv === 32'h00000000, "unmapped read");
    endtask
    task t_mark;
        int f, s, m;
        cfg(3'h6, 2'h1, 2'h1, 2'h0, 1'b1, 1'b0, 1'b1);
        ctrl.send_pulse(50, 24);
        f = frames;
        s = samples;
        m = marks;
        ctrl.send_pulse(12, 7);
        #1 chk(lineOe === 1'b1 && lineOut === 1'b1, "no mark");
        repeat (3 * TC) @(posedge clock);
        #1 chk(lineOe === 1'b0, "mark too long");
        chk(frames - f == 1 && marks - m == 1, "addressing");
        rd(A_STAT);
        chk(rdv === 32'h00000003, "slot not one");
        ctrl.send_pulse(12, 24);
        chk(samples - s == 1 && frames - f == 1, "wrap sample");
        wr(A_SLOT, 32'h00000000);
        s = samples;
        ctrl.send_pulse(12, 24);
        ctrl.send_pulse(12, 24);
        chk(samples == s, "sampled with option off");
        wr(A_MARK, 32'h00000000);
        m = marks;
        ctrl.send_pulse(12, 24);
        ctrl.send_pulse(12, 24);
        chk(marks == m, "mark with option off");
    endtask
    // options ignored outside the shared variants
    task t_variant;
        int f, s, m;
        cfg(3'h0, 2'h1, 2'h1, 2'h0, 1'b1, 1'b0, 1'b1);
        f = frames;
        s = samples;
        m = marks;
        ctrl.send_pulse(12, 24);
        ctrl.send_pulse(12, 24);
        chk(frames - f == 2 && marks == m, "plain mode mark");
        chk(samples == s, "plain mode sample");
        rd(A_STAT);
        chk(rdv === 32'h00000001, "plain mode slot");
    endtask
    task t_adjust;
        int f;
        for (int a = 0; a < 4; a++) begin
            cfg(3'h7, 2'h0, 2'h0, a[1:0], 1'b0, 1'b0, 1'b0);
            f = frames;
            ctrl.send_pulse(7 + a, 24);
            chk(frames == f, "narrow request taken");
            ctrl.send_pulse(10 + a, 24);
            chk(frames == f + 1, "request dropped");
        end
        cfg(3'h6, 2'h0, 2'h0, 2'h3, 1'b0, 1'b0, 1'b0);
        f = frames;
        ctrl.send_pulse(10, 24);
        chk(frames == f + 1, "adjust in short mode");
    endtask
    // idle resync on, then off, then a sync pulse
    task t_sync;
        int s;
        cfg(3'h6, 2'h1, 2'h1, 2'h0, 1'b0, 1'b1, 1'b1);
        ctrl.send_pulse(50, 24);
        ctrl.send_pulse(12, 24);
        s = samples;
        repeat (520 * TC) @(posedge clock);
        rd(A_STAT);
        chk(rdv === 32'h00000001, "idle resync");
        chk(samples == s + 1, "idle resync sample");
        cfg(3'h6, 2'h1, 2'h1, 2'h0, 1'b0, 1'b0, 1'b0);
        ctrl.send_pulse(12, 24);
        repeat (520 * TC) @(posedge clock);
        rd(A_STAT);
        chk(rdv === 32'h00000003, "resync while off");
        ctrl.send_pulse(50, 24);
        rd(A_STAT);
        chk(rdv === 32'h00000001, "sync pulse");
    endtask
    // second power-on with stay-offline set before the shared variant
    task t_offline;
        int f, m;
        @(posedge clock);
        rst <= 1'b1;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        wr(A_SLOT, 32'h00080000);
        cfg(3'h6, 2'h1, 2'h1, 2'h0, 1'b1, 1'b0, 1'b0);
        f = frames;
        m = marks;
        chk(online === 1'b0, "online despite stay-offline");
        ctrl.send_pulse(12, 24);
        chk(frames == f && marks == m, "sent while offline");
        rd(A_STAT);
        chk(rdv === 32'h00000002, "slot not tracked offline");
        ctrl.send_pulse(50, 24);
        rd(A_STAT);
        chk(rdv === 32'h00000001, "not online after sync");
        ctrl.send_pulse(12, 24);
        chk(frames == f + 1 && marks == m + 1, "no frame online");
    endtask

    // hang guard well beyond the expected run length
    initial begin
        #200000;
        err_count = err_count + 1;
        report_and_stop;
    end
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        t_reset;
        t_mark;
        t_variant;
        t_adjust;
        t_sync;
        t_offline;
        report_and_stop;
    end
endmodule
